// file: design/two_wire_slave.sv
/*
 Byte-level slave of the two-wire control bus: start and stop detection,
 address match, acknowledge, byte shift in and out, auto-increment hints.
 Assumes scl and sda_in are already synchronous to clk and that the bus
 runs well below a quarter of the clock rate.
*/
`timescale 1ns/100ps
module two_wire_slave
   import event_config_pkg::*;
#(
   parameter logic [6:0] bus_address = default_bus_address
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [7:0] read_data,
   output logic write_strobe,
   output logic write_is_pointer,
   output logic [7:0] write_data,
   output logic read_taken,
   output logic [7:0] read_taken_data
);

   typedef enum {
      st_idle, st_addr, st_addr_match, st_addr_ack, st_write, st_write_done,
      st_write_ack, st_read, st_read_ack, st_read_next
   } bus_state_t;

   bus_state_t state, next_state;
   logic scl_prev, sda_prev, next_scl_prev, next_sda_prev;
   logic [2:0] bit_count, next_bit_count;
   logic [7:0] shift, next_shift;
   logic first_byte, next_first_byte;
   logic next_sda_oe, next_write_strobe, next_write_is_pointer;
   logic [7:0] next_write_data, next_read_taken_data;
   logic next_read_taken;
   logic start_seen, stop_seen, scl_rise, scl_fall;

   // ==========================================================
   // Bus sequencing
   always_comb begin
      start_seen = scl && scl_prev && sda_prev && !sda_in;
      stop_seen = scl && scl_prev && !sda_prev && sda_in;
      scl_rise = scl && !scl_prev;
      scl_fall = !scl && scl_prev;
      next_scl_prev = scl;
      next_sda_prev = sda_in;
      next_state = state;
      next_bit_count = bit_count;
      next_shift = shift;
      next_first_byte = first_byte;
      next_sda_oe = sda_oe;
      next_write_strobe = 1'b0;
      next_write_is_pointer = write_is_pointer;
      next_write_data = write_data;
      next_read_taken = 1'b0;
      next_read_taken_data = read_taken_data;
      if (start_seen) begin
         // Repeated start also lands here
         next_state = st_addr;
         next_bit_count = 3'h0;
         next_sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_state = st_idle;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            st_idle: begin
               next_sda_oe = 1'b0;
            end
            st_addr, st_write: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_in};
                  next_bit_count = bit_count + 3'h1;
                  if (bit_count == last_bit_index) begin
                     next_state = (state == st_addr) ? st_addr_match
                                                     : st_write_done;
                  end
               end
            end
            st_addr_match: begin
               if (scl_fall) begin
                  if (shift[7:1] == bus_address) begin
                     next_sda_oe = 1'b1;
                     next_state = st_addr_ack;
                  end else begin
                     next_state = st_idle;
                  end
               end
            end
            st_addr_ack: begin
               if (scl_fall) begin
                  next_bit_count = 3'h0;
                  if (shift[0]) begin
                     next_shift = read_data;
                     next_sda_oe = !read_data[7];
                     next_read_taken = 1'b1;
                     next_read_taken_data = read_data;
                     next_state = st_read;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_first_byte = 1'b1;
                     next_state = st_write;
                  end
               end
            end
            st_write_done: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b1;
                  next_write_strobe = 1'b1;
                  next_write_is_pointer = first_byte;
                  next_write_data = shift;
                  next_first_byte = 1'b0;
                  next_state = st_write_ack;
               end
            end
            st_write_ack: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_bit_count = 3'h0;
                  next_state = st_write;
               end
            end
            st_read: begin
               if (scl_fall) begin
                  if (bit_count == last_bit_index) begin
                     // Release for the master's acknowledge
                     next_sda_oe = 1'b0;
                     next_state = st_read_ack;
                  end else begin
                     next_shift = {shift[6:0], 1'b0};
                     next_sda_oe = !shift[6];
                     next_bit_count = bit_count + 3'h1;
                  end
               end
            end
            st_read_ack: begin
               if (scl_rise) begin
                  next_state = sda_in ? st_idle : st_read_next;
               end
            end
            st_read_next: begin
               if (scl_fall) begin
                  next_bit_count = 3'h0;
                  next_shift = read_data;
                  next_sda_oe = !read_data[7];
                  next_read_taken = 1'b1;
                  next_read_taken_data = read_data;
                  next_state = st_read;
               end
            end
            default: begin
               next_state = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_idle;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         bit_count <= 3'h0;
         shift <= 8'h00;
         first_byte <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         write_strobe <= 1'b0;
         write_is_pointer <= 1'b0;
         write_data <= 8'h00;
         read_taken <= 1'b0;
         read_taken_data <= 8'h00;
      end else begin
         state <= next_state;
         scl_prev <= next_scl_prev;
         sda_prev <= next_sda_prev;
         bit_count <= next_bit_count;
         shift <= next_shift;
         first_byte <= next_first_byte;
         sda_oe <= next_sda_oe;
         // Open drain: the pin is only ever pulled low
         sda_out <= 1'b0;
         write_strobe <= next_write_strobe;
         write_is_pointer <= next_write_is_pointer;
         write_data <= next_write_data;
         read_taken <= next_read_taken;
         read_taken_data <= next_read_taken_data;
      end
   end

endmodule

// file: design/event_config_pkg.sv
/*
 Constants shared by the control-register slice: register offsets, field
 positions, reset values and the encodings of the configuration codes.
 Assumes an 8-bit register space reached over a two-wire control bus.
*/
package event_config_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] interrupt_config_offset = 8'h32;
   localparam logic [7:0] event_mask_offset = 8'h33;
   localparam logic [7:0] latched_event_flags_offset = 8'h36;
   localparam logic [7:0] cm_tolerance_offset = 8'h3A;
   localparam logic [7:0] bias_fullscale_offset = 8'h3B;

   // ==========================================================
   // Reset values
   localparam logic [7:0] latched_event_flags_reset = 8'h00;
   localparam logic [7:0] event_mask_reset = 8'hFF;
   localparam logic [7:0] cm_tolerance_reset = 8'h00;
   localparam logic [7:0] bias_fullscale_reset = 8'h00;
   localparam logic readback_select_reset = 1'b0;

   // ==========================================================
   // Event flag bit positions
   localparam int clock_error_bit = 7;
   localparam int pll_lock_bit = 6;
   localparam int mix_saturation_bit = 5;
   localparam int vad_power_up_bit = 4;
   localparam int vad_power_down_bit = 3;
   // Bits 7..3 carry events, 2..0 read zero
   localparam logic [7:0] event_bits = 8'hF8;

   // ==========================================================
   // Field positions
   localparam int readback_select_bit = 2;
   localparam int first_cm_tol_lsb = 6;
   localparam int second_cm_tol_lsb = 4;
   localparam int mic_bias_lsb = 4;
   localparam int full_scale_lsb = 0;
   localparam logic [7:0] cm_tolerance_writable = 8'hF0;
   localparam logic [7:0] bias_fullscale_writable = 8'h73;

   // ==========================================================
   // Codes
   localparam logic [1:0] cm_tol_narrow = 2'h0;
   localparam logic [1:0] cm_tol_one_volt = 2'h1;
   localparam logic [1:0] cm_tol_rail_to_rail = 2'h2;
   localparam logic [2:0] bias_from_reference = 3'h0;
   localparam logic [2:0] bias_from_reference_boost = 3'h1;
   localparam logic [2:0] bias_from_first_negative = 3'h2;
   localparam logic [2:0] bias_from_second_negative = 3'h3;
   localparam logic [2:0] bias_from_negative_average = 3'h4;
   localparam logic [2:0] bias_from_crude_common_mode = 3'h5;
   localparam logic [2:0] bias_from_analog_supply = 3'h6;
   localparam logic [2:0] bias_pin_as_input = 3'h7;
   localparam logic [1:0] full_scale_2v75 = 2'h0;
   localparam logic [1:0] full_scale_2v5 = 2'h1;
   localparam logic [1:0] full_scale_1v375 = 2'h2;

   // ==========================================================
   // Control bus
   // Arbitrary neutral bus address
   localparam logic [6:0] default_bus_address = 7'h4E;
   localparam logic [2:0] last_bit_index = 3'h7;

endpackage

// file: design/irq_latch_and_bias_config_regs.sv
/*
 Latched event flags, event masks, readback selection and the input
 common-mode, microphone bias and full-scale configuration registers,
 reached over the two-wire control bus.
 Assumes event inputs are synchronous to clk, level or pulse.
*/
// Operation
// R1: Clock error on serial port sets bit 7
// R2: PLL lock event sets bit 6
// R3: Mixing saturation alert sets bit 5
// R4: Voice detector power-up sets bit 4
// R5: Voice detector power-down sets bit 3
// R6: Flags read one when latched, self-clearing
// R7: Flag register at 0x36, read-only, resets zero
// R8: Two-bit tolerance fields per channel, bits 7-4
// R9: Host uses rail-to-rail only with high impedance
// R10: Bias field bits 6-4 selects bias source
// R11: Bias code 7 frees pin as input
// R12: Full-scale field bits 1-0 sets reference
// R13: Host picks full scale by supply minimum
// R14: Host never writes reserved code three
// R15: Reserved bits read zero, written reset value
// R16: Config registers at 0x3A, 0x3B reset zero
// R17: Readback bit selects all or unmasked events
// R18: Per-event mask bits, default masked
// R19: Reading flags clears them unless still signalled
`timescale 1ns/100ps
module irq_latch_and_bias_config_regs
   import event_config_pkg::*;
#(
   parameter logic [6:0] bus_address = default_bus_address
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic serial_clock_error,
   input wire logic pll_lock_event,
   input wire logic mix_saturation_alert,
   input wire logic vad_power_up_detect,
   input wire logic vad_power_down_detect,
   output logic [7:0] latched_event_flags,
   output logic [7:0] event_mask_bits,
   output logic latched_readback_select,
   output logic [1:0] first_channel_cm_tolerance,
   output logic [1:0] second_channel_cm_tolerance,
   output logic [2:0] mic_bias_select,
   output logic bias_generation_enable,
   output logic mic_pin_as_general_input,
   output logic [1:0] converter_full_scale_select
);

   logic write_strobe, write_is_pointer, read_taken;
   logic [7:0] write_data, read_taken_data, read_data;
   logic [7:0] pointer, next_pointer;
   logic [7:0] next_flags, next_mask, event_in, read_clear;
   logic next_readback_select;
   logic [1:0] next_first_tol, next_second_tol, next_full_scale;
   logic [2:0] next_bias;
   logic next_bias_enable, next_pin_as_input;

   two_wire_slave #(
      .bus_address(bus_address)
   ) bus_slave (
      .clk(clk),
      .reset_n(reset_n),
      .scl(scl),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .read_data(read_data),
      .write_strobe(write_strobe),
      .write_is_pointer(write_is_pointer),
      .write_data(write_data),
      .read_taken(read_taken),
      .read_taken_data(read_taken_data)
   );

   // ==========================================================
   // Readback
   function automatic logic [7:0] register_value(input logic [7:0] offset);
      logic [7:0] shown;
      shown = latched_event_flags;
      if (latched_readback_select) begin
         shown = shown & ~event_mask_bits; // [R17]
      end
      case (offset)
         interrupt_config_offset:
            register_value = {5'h00, latched_readback_select, 2'h0};
         event_mask_offset:
            register_value = event_mask_bits;
         latched_event_flags_offset:
            register_value = shown & event_bits; // [R6] [R7]
         cm_tolerance_offset:
            register_value = {first_channel_cm_tolerance,
                              second_channel_cm_tolerance, 4'h0}; // [R15]
         bias_fullscale_offset:
            register_value = {1'b0, mic_bias_select, 2'h0,
                              converter_full_scale_select}; // [R15]
         // Unmapped offsets read zero
         default:
            register_value = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // Register next values
   always_comb begin
      read_data = register_value(pointer);
      event_in = 8'h00;
      event_in[clock_error_bit] = serial_clock_error; // [R1]
      event_in[pll_lock_bit] = pll_lock_event; // [R2]
      event_in[mix_saturation_bit] = mix_saturation_alert; // [R3]
      event_in[vad_power_up_bit] = vad_power_up_detect; // [R4]
      event_in[vad_power_down_bit] = vad_power_down_detect; // [R5]
      // Only bits actually shipped are cleared, so hidden ones survive
      read_clear = 8'h00;
      if (read_taken && pointer == latched_event_flags_offset) begin
         read_clear = read_taken_data; // [R19]
      end
      // An event in the clearing cycle wins over the clear
      next_flags = ((latched_event_flags & ~read_clear) | event_in)
                   & event_bits; // [R6] [R19]
      next_pointer = pointer;
      next_mask = event_mask_bits;
      next_readback_select = latched_readback_select;
      next_first_tol = first_channel_cm_tolerance;
      next_second_tol = second_channel_cm_tolerance;
      next_bias = mic_bias_select;
      next_full_scale = converter_full_scale_select;
      if (write_strobe && write_is_pointer) begin
         next_pointer = write_data;
      end else if (write_strobe) begin
         next_pointer = pointer + 8'h01;
         case (pointer)
            interrupt_config_offset: begin
               next_readback_select = write_data[readback_select_bit];
            end
            event_mask_offset: begin
               next_mask = write_data; // [R18]
            end
            cm_tolerance_offset: begin
               // Code 3 is stored as written; the host must avoid it
               next_first_tol = write_data[first_cm_tol_lsb +: 2]; // [R8]
               next_second_tol = write_data[second_cm_tol_lsb +: 2]; // [R8]
            end
            bias_fullscale_offset: begin
               next_bias = write_data[mic_bias_lsb +: 3]; // [R10]
               next_full_scale = write_data[full_scale_lsb +: 2]; // [R12]
            end
            // Flag register and unmapped offsets ignore writes
            default: begin
               next_pointer = pointer + 8'h01; // [R7]
            end
         endcase
      end else if (read_taken) begin
         next_pointer = pointer + 8'h01;
      end
      next_pin_as_input = next_bias == bias_pin_as_input; // [R11]
      next_bias_enable = !next_pin_as_input; // [R11]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pointer <= 8'h00;
         latched_event_flags <= latched_event_flags_reset; // [R7]
         event_mask_bits <= event_mask_reset; // [R18]
         latched_readback_select <= readback_select_reset;
         first_channel_cm_tolerance <=
            cm_tolerance_reset[first_cm_tol_lsb +: 2]; // [R16]
         second_channel_cm_tolerance <=
            cm_tolerance_reset[second_cm_tol_lsb +: 2]; // [R16]
         mic_bias_select <= bias_fullscale_reset[mic_bias_lsb +: 3]; // [R16]
         converter_full_scale_select <=
            bias_fullscale_reset[full_scale_lsb +: 2]; // [R16]
         bias_generation_enable <= 1'b1;
         mic_pin_as_general_input <= 1'b0;
      end else begin
         pointer <= next_pointer;
         latched_event_flags <= next_flags;
         event_mask_bits <= next_mask;
         latched_readback_select <= next_readback_select;
         first_channel_cm_tolerance <= next_first_tol;
         second_channel_cm_tolerance <= next_second_tol;
         mic_bias_select <= next_bias;
         converter_full_scale_select <= next_full_scale;
         bias_generation_enable <= next_bias_enable;
         mic_pin_as_general_input <= next_pin_as_input;
      end
   end

endmodule

// file: bench/event_regs_checker.sv
/*
 Port checker for the event flag and configuration register slice.
 Assumes one clock with an async active-low reset; bound to each instance.
*/
`timescale 1ns/100ps
module event_regs_checker
   import event_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic serial_clock_error,
   input wire logic pll_lock_event,
   input wire logic mix_saturation_alert,
   input wire logic vad_power_up_detect,
   input wire logic vad_power_down_detect,
   input wire logic [7:0] latched_event_flags,
   input wire logic [7:0] event_mask_bits,
   input wire logic latched_readback_select,
   input wire logic [1:0] first_channel_cm_tolerance,
   input wire logic [1:0] second_channel_cm_tolerance,
   input wire logic [2:0] mic_bias_select,
   input wire logic bias_generation_enable,
   input wire logic mic_pin_as_general_input,
   input wire logic [1:0] converter_full_scale_select
);
   // ==========================================================
   // Helpers
   logic [7:0] ev_vec;
   logic [8:0] cfg_vec;
   assign ev_vec = {serial_clock_error, pll_lock_event, mix_saturation_alert,
      vad_power_up_detect, vad_power_down_detect, 3'h0};
   assign cfg_vec = {first_channel_cm_tolerance, second_channel_cm_tolerance,
      mic_bias_select, converter_full_scale_select};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // Assertions
   property p_set7; serial_clock_error |=> latched_event_flags[7];
   endproperty
   a_set7: assert property (p_set7)
      else $error("flag 7 not set");
   property p_set6; pll_lock_event |=> latched_event_flags[6];
   endproperty
   a_set6: assert property (p_set6)
      else $error("flag 6 not set");
   property p_set5; mix_saturation_alert |=> latched_event_flags[5];
   endproperty
   a_set5: assert property (p_set5)
      else $error("flag 5 not set");
   property p_set4; vad_power_up_detect |=> latched_event_flags[4];
   endproperty
   a_set4: assert property (p_set4)
      else $error("flag 4 not set");
   property p_set3; vad_power_down_detect |=> latched_event_flags[3];
   endproperty
   a_set3: assert property (p_set3)
      else $error("flag 3 not set");
   property p_cause;
      ((latched_event_flags & ~$past(latched_event_flags)) & ~$past(ev_vec))
         == 8'h00;
   endproperty
   a_cause: assert property (p_cause)
      else $error("flag set without its event");
   property p_rsvd; latched_event_flags[2:0] == 3'h0; endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved flag bits not zero");
   property p_pin;
      mic_pin_as_general_input == (mic_bias_select == bias_pin_as_input) &&
         bias_generation_enable == !mic_pin_as_general_input;
   endproperty
   a_pin: assert property (p_pin)
      else $error("bias pin use disagrees with bias code");
   // Configuration may only move while the device acknowledges a byte
   property p_cfg; $changed(cfg_vec) |-> $past(sda_oe); endproperty
   a_cfg: assert property (p_cfg)
      else $error("configuration changed outside a write");
   property p_clear;
      $fell(latched_event_flags[6]) |-> $past(sda_oe) && !$past(pll_lock_event);
   endproperty
   a_clear: assert property (p_clear)
      else $error("flag 6 cleared outside a read or while signalled");
   c_event: cover property (serial_clock_error);
   c_pin_input: cover property ($rose(mic_pin_as_general_input));
   c_clear: cover property ($fell(latched_event_flags[3]));
endmodule

bind irq_latch_and_bias_config_regs event_regs_checker event_regs_checker_inst
   (.clk, .reset_n, .scl, .sda_in, .sda_out, .sda_oe, .serial_clock_error,
   .pll_lock_event, .mix_saturation_alert, .vad_power_up_detect,
   .vad_power_down_detect, .latched_event_flags, .event_mask_bits,
   .latched_readback_select, .first_channel_cm_tolerance,
   .second_channel_cm_tolerance, .mic_bias_select, .bias_generation_enable,
   .mic_pin_as_general_input, .converter_full_scale_select);

// file: bench/irq_host_model.sv
/*
 Host side of the two-wire control bus, stepped from the system clock.
 Assumes a pull-up on the data line; the model only ever pulls it low.
*/
`timescale 1ns/100ps
module irq_host_model
   import event_config_pkg::*;
#(
   parameter logic [6:0] dev_addr = default_bus_address
) (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull
);
   // ==========================================================
   // Bit and byte sequencing
   int nacks = 0;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // 3+6+3 clocks per bit keeps every bus phase at least 3 clocks long
   task automatic clock_bit(input logic b, output logic seen);
      sda_pull = !b;
      tick(3);
      scl = 1'b1;
      tick(6);
      seen = sda_line;
      scl = 1'b0;
      tick(3);
   endtask
   // Start when first is 0, stop when first is 1
   task automatic cond(input logic first);
      sda_pull = first;
      tick(3);
      scl = 1'b1;
      tick(6);
      sda_pull = !first;
      tick(6);
      if (!first) begin
         scl = 1'b0;
         tick(3);
      end
   endtask
   // Ninth bit released: device ack on sends, host nack on the read byte
   task automatic xfer(input logic [7:0] d, input logic chk,
      output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) clock_bit(d[i], q[i]);
      clock_bit(1'b1, a);
      if (a && chk) nacks++;
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      cond(1'b0);
      xfer({dev_addr, 1'b0}, 1'b1, q);
      xfer(a, 1'b1, q);
      xfer(d, 1'b1, q);
      cond(1'b1);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      cond(1'b0);
      xfer({dev_addr, 1'b0}, 1'b1, q);
      xfer(a, 1'b1, q);
      cond(1'b0);
      xfer({dev_addr, 1'b1}, 1'b1, q);
      xfer(8'hFF, 1'b0, d);
      cond(1'b1);
   endtask
endmodule

// file: bench/tb_top.sv
/*
 Self-checking bench for the event flag and configuration slice.
 Drives the bus through the host model and the event inputs directly.
*/
`timescale 1ns/100ps
module tb_top
   import event_config_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl, sda_pull, sda_out, sda_oe, readback, bias_en, pin_in;
   wire logic sda_line;
   logic [4:0] ev = 5'h00;
   logic [7:0] flags, masks;
   logic [1:0] cm1, cm2, fs;
   logic [2:0] bias;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   always #20 clk = !clk;
   // Open drain with pull-up
   assign sda_line = !((sda_oe && !sda_out) || sda_pull);
   irq_latch_and_bias_config_regs irq_latch_and_bias_config_regs_inst (
      .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .serial_clock_error(ev[4]),
      .pll_lock_event(ev[3]), .mix_saturation_alert(ev[2]),
      .vad_power_up_detect(ev[1]), .vad_power_down_detect(ev[0]),
      .latched_event_flags(flags), .event_mask_bits(masks),
      .latched_readback_select(readback),
      .first_channel_cm_tolerance(cm1), .second_channel_cm_tolerance(cm2),
      .mic_bias_select(bias), .bias_generation_enable(bias_en),
      .mic_pin_as_general_input(pin_in),
      .converter_full_scale_select(fs));
   irq_host_model irq_host_model_inst (.clk(clk), .sda_line(sda_line),
      .scl(scl), .sda_pull(sda_pull));
   // ==========================================================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      irq_host_model_inst.read_reg(a, d);
      check8($sformatf("reg %h", a), exp, d);
   endtask
   task automatic pulse(input logic [4:0] e);
      ev = e;
      tick(1);
      ev = 5'h00;
   endtask
   task automatic conclude();
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         conclude();
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      logic [7:0] v;
      tick(2);
      reset_n = 1'b1;
      tick(2);
      read_check(latched_event_flags_offset, 8'h00);
      read_check(cm_tolerance_offset, 8'h00);
      read_check(bias_fullscale_offset, 8'h00);
      read_check(event_mask_offset, 8'hFF);
      // Codes 0..2 only; code 3 is never written
      for (int i = 0; i < 3; i++) begin
         v = {i[1:0], 2'(2 - i), 4'h0};
         irq_host_model_inst.write_reg(cm_tolerance_offset, v);
         read_check(cm_tolerance_offset, v);
         check8("cm1", {6'h00, v[7:6]}, {6'h00, cm1});
         check8("cm2", {6'h00, v[5:4]}, {6'h00, cm2});
      end
      for (int b = 0; b < 8; b++) begin
         v = {1'b0, 3'(b), 2'b00, 2'(b % 3)};
         irq_host_model_inst.write_reg(bias_fullscale_offset, v);
         read_check(bias_fullscale_offset, v);
         check8("bias", 8'(b), {5'h00, bias});
         check8("fs", 8'(b % 3), {6'h00, fs});
         check8("pin_in", 8'(b == 7), {7'h00, pin_in});
         check8("bias_en", 8'(b != 7), {7'h00, bias_en});
      end
      reset_n = 1'b0;
      tick(2);
      reset_n = 1'b1;
      tick(2);
      check8("bias_en", 8'h01, {7'h00, bias_en});
      read_check(bias_fullscale_offset, 8'h00);
      for (int k = 0; k < 5; k++) begin
         pulse(5'(1 << k));
         v = 8'(8 << k);
         check8("flags", v, flags);
         read_check(latched_event_flags_offset, v);
         check8("flags", 8'h00, flags);
      end
      // Event still high across the read: set wins over clear
      ev = 5'h08;
      tick(1);
      read_check(latched_event_flags_offset, 8'h40);
      check8("flags", 8'h40, flags);
      ev = 5'h00;
      read_check(latched_event_flags_offset, 8'h40);
      check8("flags", 8'h00, flags);
      irq_host_model_inst.write_reg(event_mask_offset, 8'h7F);
      irq_host_model_inst.write_reg(interrupt_config_offset, 8'h04);
      read_check(interrupt_config_offset, 8'h04);
      check8("readback", 8'h01, {7'h00, readback});
      check8("masks", 8'h7F, masks);
      pulse(5'h18);
      read_check(latched_event_flags_offset, 8'h80);
      check8("flags", 8'h40, flags);
      irq_host_model_inst.write_reg(interrupt_config_offset, 8'h00);
      read_check(latched_event_flags_offset, 8'h40);
      check8("flags", 8'h00, flags);
      pulse(5'h01);
      irq_host_model_inst.write_reg(latched_event_flags_offset, 8'h00);
      check8("flags", 8'h08, flags);
      check8("nacks", 8'h00, 8'(irq_host_model_inst.nacks));
      conclude();
   end
endmodule
